// file: core/ldsr_led_driver_status_readback.sv
// ldsr top: status readback, boost feedback fault handling and Avalon-MM register slave
//
// What this block does
// RULE1 - feedback pin short to ground sets the boost feedback fault flag, bit 6
// RULE2 - with fault set and boost off, boost may not start
// RULE3 - fault setting while boost runs switches boost off at once
// RULE4 - while fault is set no sync clock leaves the sync pin
// RULE5 - fault in fallback safe mode also pulls the compensation pin low
// RULE6 - fault flag is never set while the boost off setting is one
// RULE7 - boost stays disabled until a read-clear of the fault is acknowledged; in fallback safe mode the auto retry wrap also clears it and boost restarts
// RULE8 - fallback safe mode clears the fault every auto retry period
// RULE9 - bit 5 is a read-only filtered copy of the direct input pin
// RULE10 - bit 0 is odd parity; unused bits read zero
// RULE11 - bits 23..16 hold string 1 off-time voltage, read-clear
// RULE12 - bits 15..8 hold string 2 off-time voltage, read-clear
// RULE13 - pin or command switched buck refreshes its field all through off-state
// RULE14 - dimming generator buck refreshes once per period before off-phase ends
// RULE15 - watchdog progress reports elapsed time in four bands
// RULE16 - overvoltage flag is not set while the fault flag is one
// RULE17 - reading the voltage register returns fields then zeroes them
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module ldsr_led_driver_status_readback
	import ldsr_pkg::*;
#(
	parameter int AUTO_RETRY_CYCLES = AUTO_RETRY_CYC,
	parameter int FILTER_CYCLES = FILTER_CYC,
	parameter int SYNC_HALF_CYCLES = SYNC_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic fbShortRaw,
	input wire logic dinRaw,
	input wire logic ovpRaw,
	input wire logic fallbackSafeMode,
	input wire ldsr_adc_in_t adcCh1,
	input wire ldsr_adc_in_t adcCh2,
	input wire logic [15:0] wdElapsed,
	input wire logic [15:0] wdLimit,
	output logic boostRun_q,
	output logic syncIoOut_q,
	output logic syncIoOe_q,
	output logic compPullOut_q,
	output logic compPullOe_q,
	output logic irq_q
);
	// ------------------------------------------------------------------
	// local sizes
	// ------------------------------------------------------------------
	localparam int RW = $clog2(AUTO_RETRY_CYCLES + 1);
	localparam logic [RW-1:0] RETRY_LAST = RW'(AUTO_RETRY_CYCLES - 1);
	localparam int SW = $clog2(SYNC_HALF_CYCLES + 1);
	localparam logic [SW-1:0] SYNC_LAST = SW'(SYNC_HALF_CYCLES - 1);
	localparam int PAD_W = DATA_W - FRAME_W;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	ldsr_bus_state_t state_q;
	ldsr_bus_state_t state_d;
	logic boostFeedbackFault_q;
	logic boostOvervoltageFlag_q;
	logic [CTL_W-1:0] control_q;
	logic [IRQ_W-1:0] irqStat_q;
	logic [IRQ_W-1:0] irqMask_q;
	logic [RW-1:0] retryCnt_q;
	logic [SW-1:0] syncCnt_q;
	logic directInputPrev_q;
	logic [1:0] watchdogProgress_q;
	logic fbShortLvl;
	logic ovpLvl;
	logic directInputState;
	logic [7:0] string1OfftimeVoltage;
	logic [7:0] string2OfftimeVoltage;
	logic adc1Refreshed;
	logic adc2Refreshed;

	// ------------------------------------------------------------------
	// pin conditioning
	// ------------------------------------------------------------------
	ldsr_level_filter #(
		.CYCLES(1)
	) u_fb_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinRaw(fbShortRaw),
		.level_q(fbShortLvl)
	);

	ldsr_level_filter #(
		.CYCLES(1)
	) u_ovp_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinRaw(ovpRaw),
		.level_q(ovpLvl)
	);

	// direct input replica uses the full input filter time
	ldsr_level_filter #(
		.CYCLES(FILTER_CYCLES)
	) u_din_filter ( // RULE9
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinRaw(dinRaw),
		.level_q(directInputState)
	);

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	wire logic [5:0] regIdx = avs_address[ADDR_W-1:2];
	wire logic busReq = avs_read || avs_write;
	wire logic takeReq = (state_q == BUS_IDLE) && busReq;
	wire logic commit = state_q == BUS_ANSWER;
	wire logic rdCommit = commit && avs_read;
	wire logic wrCommit = commit && avs_write && avs_byteenable[0];
	wire logic hitStatus2 = regIdx == IDX_STATUS2;
	wire logic hitVoltage = regIdx == IDX_VOLTAGE;
	wire logic hitIrqStat = regIdx == IDX_IRQ_STAT;
	wire logic hitIrqMask = regIdx == IDX_IRQ_MASK;
	wire logic hitControl = regIdx == IDX_CONTROL;
	wire logic clearFaultCmd = rdCommit && hitStatus2; // RULE7
	wire logic clearVoltage = rdCommit && hitVoltage; // RULE17
	wire logic boostOnCmd = control_q[CTL_BOOST_ON];
	wire logic boostOffSetting = control_q[CTL_BOOST_OFF];

	always_comb begin
		case (state_q)
			BUS_IDLE: state_d = takeReq ? BUS_ANSWER : BUS_IDLE;
			BUS_ANSWER: state_d = BUS_IDLE;
			default: state_d = BUS_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// boost feedback fault
	// ------------------------------------------------------------------
	wire logic retryWrap = fallbackSafeMode && (retryCnt_q == RETRY_LAST);
	wire logic [RW-1:0] retryCnt_d = (!fallbackSafeMode || retryWrap) ? '0 : retryCnt_q + 1'b1;
	wire logic faultSet = fbShortLvl && !boostOffSetting; // RULE1 RULE6
	wire logic faultClear = clearFaultCmd || retryWrap; // RULE7 RULE8
	// a short still present at the clear keeps the flag set
	wire logic fault_d = faultSet || (boostFeedbackFault_q && !faultClear);
	wire logic boostRun_d = boostOnCmd && !boostOffSetting && !fault_d; // RULE2 RULE3 RULE7
	wire logic syncIoOe_d = !fault_d; // RULE4
	wire logic compPullOe_d = fault_d && fallbackSafeMode; // RULE5
	wire logic ovp_d = ovpLvl && !fault_d && !boostOffSetting; // RULE16

	// ------------------------------------------------------------------
	// sync clock divider
	// ------------------------------------------------------------------
	wire logic syncWrap = syncCnt_q == SYNC_LAST;
	wire logic [SW-1:0] syncCnt_d = syncWrap ? '0 : syncCnt_q + 1'b1;
	// held low while disabled so re-enable starts on a clean edge
	wire logic syncIoOut_d = syncIoOe_d ? (syncIoOut_q ^ syncWrap) : 1'b0; // RULE4

	// ------------------------------------------------------------------
	// off-time voltage fields
	// ------------------------------------------------------------------
	ldsr_adc_field u_adc1 ( // RULE11
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.ch(adcCh1),
		.clearReq(clearVoltage),
		.field_q(string1OfftimeVoltage),
		.refreshed_q(adc1Refreshed)
	);

	ldsr_adc_field u_adc2 ( // RULE12
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.ch(adcCh2),
		.clearReq(clearVoltage),
		.field_q(string2OfftimeVoltage),
		.refreshed_q(adc2Refreshed)
	);

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	wire logic [IRQ_W-1:0] irqEvent = {directInputState != directInputPrev_q,
		adc2Refreshed, adc1Refreshed, faultSet && !boostFeedbackFault_q};
	wire logic [IRQ_W-1:0] irqW1c = (wrCommit && hitIrqStat) ? avs_writedata[IRQ_W-1:0] : '0;
	wire logic [IRQ_W-1:0] irqStat_d = (irqStat_q & ~irqW1c) | irqEvent;
	wire logic [IRQ_W-1:0] irqMask_d = (wrCommit && hitIrqMask) ? avs_writedata[IRQ_W-1:0]
		: irqMask_q;
	wire logic [CTL_W-1:0] control_d = (wrCommit && hitControl) ? avs_writedata[CTL_W-1:0]
		: control_q;

	// ------------------------------------------------------------------
	// readback frames
	// ------------------------------------------------------------------
	logic [FRAME_W-1:0] status2Body;
	logic [FRAME_W-1:0] voltageBody;

	always_comb begin
		status2Body = '0;
		status2Body[BIT_WD_HI:BIT_WD_LO] = watchdogProgress_q; // RULE15
		status2Body[BIT_OVP] = boostOvervoltageFlag_q;
		status2Body[BIT_FAULT] = boostFeedbackFault_q; // RULE1
		status2Body[BIT_DIN] = directInputState; // RULE9
	end

	always_comb begin
		voltageBody = '0;
		voltageBody[V1_HI:V1_LO] = string1OfftimeVoltage; // RULE11
		voltageBody[V2_HI:V2_LO] = string2OfftimeVoltage; // RULE12
	end

	wire logic [FRAME_W-1:0] status2Frame = parityFrame(status2Body); // RULE10
	wire logic [FRAME_W-1:0] voltageFrame = parityFrame(voltageBody); // RULE10
	// unmapped addresses read zero and writes to them are dropped
	wire logic [DATA_W-1:0] readMux =
		hitStatus2 ? {{PAD_W{1'b0}}, status2Frame} :
		hitVoltage ? {{PAD_W{1'b0}}, voltageFrame} :
		hitIrqStat ? {{(DATA_W-IRQ_W){1'b0}}, irqStat_q} :
		hitIrqMask ? {{(DATA_W-IRQ_W){1'b0}}, irqMask_q} :
		hitControl ? {{(DATA_W-CTL_W){1'b0}}, control_q} : '0;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_q <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			state_q <= state_d;
			avs_waitrequest <= !takeReq;
			avs_readdata <= (takeReq && avs_read) ? readMux : avs_readdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			boostFeedbackFault_q <= 1'b0;
			boostOvervoltageFlag_q <= 1'b0;
			boostRun_q <= 1'b0;
			syncIoOe_q <= 1'b0;
			syncIoOut_q <= 1'b0;
			compPullOe_q <= 1'b0;
			compPullOut_q <= 1'b0;
		end else begin
			boostFeedbackFault_q <= fault_d;
			boostOvervoltageFlag_q <= ovp_d;
			boostRun_q <= boostRun_d;
			syncIoOe_q <= syncIoOe_d;
			syncIoOut_q <= syncIoOut_d;
			compPullOe_q <= compPullOe_d;
			compPullOut_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			retryCnt_q <= '0;
			syncCnt_q <= '0;
			control_q <= CTL_RESET;
			irqStat_q <= IRQ_RESET;
			irqMask_q <= IRQ_RESET;
			irq_q <= 1'b0;
			directInputPrev_q <= 1'b0;
			watchdogProgress_q <= WD_Q0;
		end else begin
			retryCnt_q <= retryCnt_d;
			syncCnt_q <= syncCnt_d;
			control_q <= control_d;
			irqStat_q <= irqStat_d;
			irqMask_q <= irqMask_d;
			irq_q <= |(irqStat_q & irqMask_q);
			directInputPrev_q <= directInputState;
			watchdogProgress_q <= wdBand(wdElapsed, wdLimit); // RULE15
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_fault_sets: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE1
		fbShortLvl && !boostOffSetting |=> boostFeedbackFault_q)
		else $error("fault flag not set after feedback short");

	a_no_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE2
		boostFeedbackFault_q && !boostRun_q && !faultClear |=> !boostRun_q)
		else $error("boost started while fault set");

	a_fault_stops: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE3
		boostFeedbackFault_q |-> !boostRun_q)
		else $error("boost running with fault set");

	a_sync_silent: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
		boostFeedbackFault_q |-> !syncIoOe_q && !syncIoOut_q)
		else $error("sync clock delivered during fault");

	a_comp_pull: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE5
		$past(fallbackSafeMode) && $rose(boostFeedbackFault_q) |-> compPullOe_q)
		else $error("comp not pulled low in safe mode fault");

	a_never_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE6
		boostOffSetting && !boostFeedbackFault_q |=> !boostFeedbackFault_q)
		else $error("fault set while boost off setting is one");

	a_fault_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE7
		boostFeedbackFault_q && !clearFaultCmd && !retryWrap |=> boostFeedbackFault_q)
		else $error("fault cleared without read-clear");

	a_auto_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE8
		retryWrap && !fbShortLvl && boostFeedbackFault_q |=> !boostFeedbackFault_q)
		else $error("auto retry did not clear fault");

	a_parity_odd: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE10
		$fell(avs_waitrequest) && avs_read && (hitStatus2 || hitVoltage)
		|-> (^avs_readdata[FRAME_W-1:0]) && (avs_readdata[DATA_W-1:FRAME_W] == '0))
		else $error("status frame parity not odd");

	a_direct_load: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE13
		adcCh1.strobe && adcCh1.buckOff && !adcCh1.pwmMode
		|=> string1OfftimeVoltage == $past(adcCh1.sample))
		else $error("string 1 field not refreshed in off-state");

	a_pwm_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE14
		adcCh2.pwmMode && !adcCh2.offEnding && !clearVoltage
		|=> $stable(string2OfftimeVoltage))
		else $error("string 2 field moved outside off-phase end");

	a_ovp_block: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE16
		boostFeedbackFault_q |-> !boostOvervoltageFlag_q)
		else $error("overvoltage flag set during fault");

	a_read_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE17
		clearVoltage && !adcCh1.strobe && !adcCh2.strobe
		|=> string1OfftimeVoltage == ADC_RESET && string2OfftimeVoltage == ADC_RESET)
		else $error("voltage fields not cleared by read");

	a_bus_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
		takeReq |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after take");
endmodule // ldsr_led_driver_status_readback

// file: core/ldsr_pkg.sv
// ldsr package: register map, field layout, timing constants, carriers and helpers
package ldsr_pkg;
	// ------------------------------------------------------------------
	// register map (word index, byte address is four times the index)
	// ------------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int FRAME_W = 24;
	localparam logic [5:0] IDX_STATUS2 = 6'h06;
	localparam logic [5:0] IDX_VOLTAGE = 6'h07;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
	localparam logic [5:0] IDX_CONTROL = 6'h12;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BIT_WD_HI = 16;
	localparam int BIT_WD_LO = 15;
	localparam int BIT_OVP = 7;
	localparam int BIT_FAULT = 6;
	localparam int BIT_DIN = 5;
	localparam int V1_HI = 23;
	localparam int V1_LO = 16;
	localparam int V2_HI = 15;
	localparam int V2_LO = 8;
	localparam int CTL_BOOST_ON = 0;
	localparam int CTL_BOOST_OFF = 1;
	localparam int CTL_W = 2;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_ADC1 = 1;
	localparam int IRQ_ADC2 = 2;
	localparam int IRQ_DIN = 3;
	localparam int IRQ_W = 4;
	localparam logic [CTL_W-1:0] CTL_RESET = 2'h0;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	localparam logic [7:0] ADC_RESET = 8'h00;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int FILTER_TIME_NS = 50000;
	localparam int FILTER_CYC = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AUTO_RETRY_NS = 10000000;
	localparam int AUTO_RETRY_CYC = AUTO_RETRY_NS / CLK_PERIOD_NS;
	localparam int SYNC_HALF_NS = 500;
	localparam int SYNC_HALF_CYC = SYNC_HALF_NS / CLK_PERIOD_NS;
	localparam int WD_BAND1 = 24;
	localparam int WD_BAND2 = 50;
	localparam int WD_BAND3 = 74;
	localparam int WD_FULL = 100;
	localparam logic [1:0] WD_Q0 = 2'h0;
	localparam logic [1:0] WD_Q1 = 2'h1;
	localparam logic [1:0] WD_Q2 = 2'h2;
	localparam logic [1:0] WD_Q3 = 2'h3;

	// ------------------------------------------------------------------
	// carriers and states
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sample;
		logic strobe;
		logic buckOff;
		logic pwmMode;
		logic offEnding;
	} ldsr_adc_in_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} ldsr_bus_state_t;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [FRAME_W-1:0] parityFrame(input logic [FRAME_W-1:0] body);
		return {body[FRAME_W-1:1], ~(^body[FRAME_W-1:1])};
	endfunction

	function automatic logic [1:0] wdBand(input logic [15:0] el, input logic [15:0] lim);
		logic [23:0] e;
		logic [23:0] l;
		e = 24'(el) * 24'(WD_FULL);
		l = 24'(lim);
		if (e < l * 24'(WD_BAND1))
			return WD_Q0;
		else if (e < l * 24'(WD_BAND2))
			return WD_Q1;
		else if (e < l * 24'(WD_BAND3))
			return WD_Q2;
		return WD_Q3;
	endfunction
endpackage

// file: core/ldsr_level_filter.sv
// ldsr level filter: two-flop synchroniser followed by a stability counter
`timescale 1ns/1ps
module ldsr_level_filter
	import ldsr_pkg::*;
#(
	parameter int CYCLES = FILTER_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic pinRaw,
	output logic level_q
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic meta_q;
	logic sync_q;
	logic [CW-1:0] cnt_q;
	wire logic differs = sync_q != level_q;
	wire logic settle = differs && (cnt_q == LAST);
	wire logic [CW-1:0] cnt_d = (!differs || settle) ? '0 : cnt_q + 1'b1;

	// glitches shorter than the filter time restart the count and never pass
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			cnt_q <= '0;
			level_q <= 1'b0;
		end else begin
			meta_q <= pinRaw;
			sync_q <= meta_q;
			cnt_q <= cnt_d;
			level_q <= settle ? sync_q : level_q;
		end
	end
endmodule // ldsr_level_filter

// file: core/ldsr_adc_field.sv
// ldsr adc field: one string's off-time voltage field with read-clear
`timescale 1ns/1ps
module ldsr_adc_field
	import ldsr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire ldsr_adc_in_t ch,
	input wire logic clearReq,
	output logic [7:0] field_q,
	output logic refreshed_q
);
	// dimming generator: one sample per period at the end of off-phase
	wire logic refresh = ch.strobe && (ch.pwmMode ? ch.offEnding : ch.buckOff); // RULE13 RULE14
	// a fresh sample beats a clear landing in the same cycle
	wire logic [7:0] field_d = refresh ? ch.sample : (clearReq ? ADC_RESET : field_q); // RULE17

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			field_q <= ADC_RESET;
			refreshed_q <= 1'b0;
		end else begin
			field_q <= field_d;
			refreshed_q <= refresh;
		end
	end
endmodule // ldsr_adc_field

// file: test/ldsr_led_driver_status_readback_test.sv
// ldsr bench: self-checking testbench for the status readback block
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin nErrors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ldsr_led_driver_status_readback_test
	import ldsr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
	logic [DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic fbShortRaw = 1'b0;
	logic dinRaw = 1'b0;
	logic ovpRaw = 1'b0;
	logic fallbackSafeMode = 1'b0;
	ldsr_adc_in_t adcCh1 = '0;
	ldsr_adc_in_t adcCh2 = '0;
	logic [15:0] wdElapsed = 16'h0000;
	logic [15:0] wdLimit = 16'h0064;
	logic boostRun_q, syncIoOut_q, syncIoOe_q, compPullOut_q, compPullOe_q, irq_q;
	logic [31:0] rdat;
	int nErrors = 0;
	int nChecks = 0;

	always #25 ref_clk = ~ref_clk;

	ldsr_led_driver_status_readback #(.AUTO_RETRY_CYCLES(20), .FILTER_CYCLES(4),
		.SYNC_HALF_CYCLES(10)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .fbShortRaw(fbShortRaw), .dinRaw(dinRaw),
		.ovpRaw(ovpRaw), .fallbackSafeMode(fallbackSafeMode), .adcCh1(adcCh1),
		.adcCh2(adcCh2), .wdElapsed(wdElapsed), .wdLimit(wdLimit), .boostRun_q(boostRun_q),
		.syncIoOut_q(syncIoOut_q), .syncIoOe_q(syncIoOe_q), .compPullOut_q(compPullOut_q),
		.compPullOe_q(compPullOe_q), .irq_q(irq_q));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] st2(logic [1:0] b, logic ov, logic f, logic d);
		logic [23:0] x;
		x = {7'h00, b, 7'h00, ov, f, d, 5'h00};
		return {8'h00, x[23:1], ~(^x[23:1])};
	endfunction

	function automatic logic [31:0] vlt(logic [7:0] a, logic [7:0] b);
		return {8'h00, a, b, 7'h00, ~(^{a, b})};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic endOfTest();
		if (nErrors == 0 && nChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// waits for waitrequest low, no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			nErrors++;
			endOfTest();
		end
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic adc(input logic two, input logic [7:0] s, input logic pwm, input logic e);
		ldsr_adc_in_t v;
		v = '{sample: s, strobe: 1'b1, buckOff: ~pwm, pwmMode: pwm, offEnding: e};
		@(posedge ref_clk);
		if (two)
			adcCh2 <= v;
		else
			adcCh1 <= v;
		@(posedge ref_clk);
		adcCh1.strobe <= 1'b0;
		adcCh2.strobe <= 1'b0;
		tick(3);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic tResetAndWatchdog();
		logic [15:0] el [8] = '{0, 23, 24, 49, 50, 73, 74, 100};
		`CHK(avs_waitrequest, 1'b1)
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 0))
		bus(1'b0, 8'h1C, 0); `CHK(rdat, vlt(8'h00, 8'h00))
		bus(1'b0, 8'h48, 0); `CHK(rdat, 32'h0000_0000)
		bus(1'b0, 8'h04, 0); `CHK(rdat, 32'h0000_0000)
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			wdElapsed <= el[i];
			tick(2);
			bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'(i / 2), 0, 0, 0))
		end
		wdElapsed <= 16'h0000;
	endtask

	task automatic tDirectInput();
		@(posedge ref_clk);
		dinRaw <= 1'b1;
		tick(2);
		dinRaw <= 1'b0;
		tick(10);
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 0))
		dinRaw <= 1'b1;
		tick(10);
		bus(1'b1, 8'h18, 32'h0000_0000);
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 1))
	endtask

	task automatic tFault();
		logic s;
		bus(1'b1, 8'h44, 32'h0000_0001);
		bus(1'b1, 8'h48, 32'h0000_0001);
		tick(2);
		`CHK(boostRun_q, 1'b1)
		`CHK(syncIoOe_q, 1'b1)
		`CHK(irq_q, 1'b0)
		s = syncIoOut_q;
		tick(10);
		`CHK(syncIoOut_q, ~s)
		fbShortRaw <= 1'b1;
		tick(6);
		`CHK(boostRun_q, 1'b0)
		`CHK(syncIoOe_q, 1'b0)
		`CHK(compPullOe_q, 1'b0)
		`CHK(irq_q, 1'b1)
		fbShortRaw <= 1'b0;
		tick(10);
		`CHK(boostRun_q, 1'b0)
		`CHK(syncIoOut_q, 1'b0)
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 1, 1))
		tick(3);
		`CHK(boostRun_q, 1'b1)
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 1))
		bus(1'b0, 8'h40, 0); `CHK(rdat, 32'h0000_0009)
		bus(1'b1, 8'h40, 32'h0000_000F);
		tick(2);
		`CHK(irq_q, 1'b0)
		bus(1'b1, 8'h44, 32'h0000_0000);
	endtask

	task automatic tBoostOffSetting();
		bus(1'b1, 8'h48, 32'h0000_0003);
		fbShortRaw <= 1'b1;
		ovpRaw <= 1'b1;
		tick(5);
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 1))
		`CHK(boostRun_q, 1'b0)
		fbShortRaw <= 1'b0;
		bus(1'b1, 8'h48, 32'h0000_0001);
		tick(4);
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 1, 0, 1))
		fbShortRaw <= 1'b1;
		tick(4);
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 1, 1))
		fbShortRaw <= 1'b0;
		ovpRaw <= 1'b0;
		tick(4);
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 1, 1))
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 1))
	endtask

	task automatic tSafeMode();
		@(posedge ref_clk);
		fallbackSafeMode <= 1'b1;
		fbShortRaw <= 1'b1;
		tick(5);
		fbShortRaw <= 1'b0;
		`CHK(compPullOe_q, 1'b1)
		`CHK(compPullOut_q, 1'b0)
		`CHK(syncIoOe_q, 1'b0)
		tick(25);
		`CHK(compPullOe_q, 1'b0)
		bus(1'b0, 8'h18, 0); `CHK(rdat, st2(2'h0, 0, 0, 1))
		fallbackSafeMode <= 1'b0;
	endtask

	task automatic tVoltage();
		bus(1'b1, 8'h40, 32'h0000_000F);
		adc(1'b0, 8'h11, 1'b0, 1'b0);
		adc(1'b0, 8'hA5, 1'b0, 1'b0);
		adc(1'b1, 8'h5A, 1'b1, 1'b1);
		adc(1'b1, 8'h3C, 1'b1, 1'b0);
		bus(1'b0, 8'h1C, 0); `CHK(rdat, vlt(8'hA5, 8'h5A))
		bus(1'b0, 8'h1C, 0); `CHK(rdat, vlt(8'h00, 8'h00))
		adc(1'b1, 8'hC3, 1'b0, 1'b0);
		bus(1'b0, 8'h1C, 0); `CHK(rdat, vlt(8'h00, 8'hC3))
		bus(1'b0, 8'h40, 0); `CHK(rdat, 32'h0000_0006)
		bus(1'b1, 8'h44, 32'h0000_0006);
		bus(1'b0, 8'h44, 0); `CHK(rdat, 32'h0000_0006)
		tick(2);
		`CHK(irq_q, 1'b1)
		bus(1'b1, 8'h40, 32'h0000_0002);
		tick(2);
		`CHK(irq_q, 1'b1)
		bus(1'b1, 8'h40, 32'h0000_0004);
		tick(2);
		`CHK(irq_q, 1'b0)
	endtask

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		tick(12);
		reset_n <= 1'b1;
		tick(2);
		tResetAndWatchdog();
		tDirectInput();
		tFault();
		tBoostOffSetting();
		tSafeMode();
		tVoltage();
		endOfTest();
	end

	initial begin
		tick(5000);
		nErrors++;
		endOfTest();
	end
endmodule // ldsr_led_driver_status_readback_test
